/* rtl/etc_timer.sv */
// Notes on behaviour
// - count is 8 bits, zero to all ones; zero gives the bottom indication
// - top of sequence is all ones or compare value A, chosen by mode
// - tick comes from io clock, or crystal pins when async select is set
// - clock select zero stops the counter; no tick is made
// - each tick clears, increments or decrements count as the mode says
// - software reads and writes count anytime; its write beats count or clear
// - three-bit waveform mode: two bits in control A, one in control B
// - overflow and compare flags in one register, each gated by its mask bit
// - count is compared with both compare values continuously
// - a match sets that channel flag on the next tick; may request interrupt
// - a flag clears when serviced or when software writes one to it
// - compare values double buffered in PWM modes only
// - buffered value moves to active register only at top or bottom
// - compare access reaches buffer when buffered, active register otherwise
// - force strobe acts like a match in non-PWM modes, without flag or clear
// - a count write blocks all matches on the following tick, even stopped
// - channel output state is kept across waveform mode changes
// - compare output mode is not buffered; changes act at once
// - waveform built from match, mode, output mode, top and bottom
// - overflow flag set as the mode says and can raise an interrupt
// - output mode zero takes no action on a match, in any mode
// - nonzero output mode puts channel output on the pin; direction stays port's
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module etc_timer (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // crystal oscillator pin
  input wire logic I_XTAL_OSC,
  // interrupt requests and service acknowledges, indexed by flag bit
  output logic [2:0] O_IRQ_REQ,
  input wire logic [2:0] I_IRQ_SVC,
  // port pins of the two channels
  input wire logic [1:0] I_PORT_DATA,
  input wire logic [1:0] I_PORT_DIR,
  output wire logic [1:0] O_CH_PIN,
  output wire logic [1:0] O_CH_PIN_OE
);
  import etc_pkg::*;

  logic ack_q;
  logic [31:0] rdat_q;
  etc_ctrl_a_s ctrl_a_q;
  etc_ctrl_b_s ctrl_b_q;
  logic [7:0] cnt_q, cnt_d;
  logic dir_up_q;
  logic [2:0] flg_q, msk_q;
  logic async_q, blk_q;
  logic tick;

  // bus decode: write lands on the edge where the master sees ack
  wire req = I_WB_CYC & I_WB_STB;
  wire wr_go = req & ack_q & I_WB_WE & I_WB_SEL[0];
  wire [7:0] wdat = I_WB_DAT[7:0];
  wire sel_ca = (I_WB_ADR == OFF_CTRL_A);
  wire sel_cb = (I_WB_ADR == OFF_CTRL_B);
  wire sel_cnt = (I_WB_ADR == OFF_COUNT);
  wire sel_flg = (I_WB_ADR == OFF_FLAGS);
  wire sel_msk = (I_WB_ADR == OFF_MASK);
  wire sel_asy = (I_WB_ADR == OFF_ASYNC);
  wire [NUM_CH-1:0] sel_ocr = {I_WB_ADR == OFF_CMP_B, I_WB_ADR == OFF_CMP_A};
  wire wr_ca = wr_go & sel_ca;
  wire wr_cb = wr_go & sel_cb;
  wire wr_cnt = wr_go & sel_cnt;
  wire wr_flg = wr_go & sel_flg;
  wire wr_msk = wr_go & sel_msk;
  wire wr_asy = wr_go & sel_asy;
  wire [NUM_CH-1:0] wr_ocr = {NUM_CH{wr_go}} & sel_ocr;

  // mode decode
  wire etc_wgm_e wgm = etc_wgm_e'({ctrl_b_q.wgm_hi, ctrl_a_q.wgm_lo});
  wire pwm = wgm[0];
  wire fast = wgm[1] & wgm[0];
  wire pc = ~wgm[1] & wgm[0];
  wire ctc = (wgm == WGM_CTC);
  wire etc_cs_e cs = etc_cs_e'(ctrl_b_q.cs);

  // per-channel wires
  logic [7:0] ocr_act [NUM_CH];
  logic [7:0] ocr_rd [NUM_CH];
  wire [NUM_CH-1:0] match;
  wire [NUM_CH-1:0] mev;
  wire [NUM_CH-1:0] frc;
  wire [NUM_CH-1:0] oc_vec;
  wire [1:0] com [NUM_CH];

  assign com[0] = ctrl_a_q.com_a;
  assign com[1] = ctrl_a_q.com_b;

  // counter unit indications
  wire [7:0] top_val = (wgm[2] | ctc) ? ocr_act[0] : CNT_MAX;
  wire at_top = (cnt_q == top_val);
  wire at_bot = (cnt_q == CNT_BOTTOM);
  wire at_max = (cnt_q == CNT_MAX);
  wire clr_cnt = (ctc | fast) & at_top;
  wire turn_dn = pc & dir_up_q & at_top;
  wire turn_up = pc & ~dir_up_q & at_bot;
  wire up_eff = pc ? (dir_up_q ? ~at_top : at_bot) : 1'b1;
  wire ovf_ev = tick & (fast ? at_top : pc ? turn_up : at_max);
  wire upd = tick & (fast ? at_top : turn_dn);

  // count write has priority over clear and count
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) cnt_d = wdat;
    else if (tick && clr_cnt) cnt_d = CNT_BOTTOM;
    else if (tick && up_eff) cnt_d = cnt_q + 8'h01;
    else if (tick) cnt_d = cnt_q - 8'h01;
  end

  wire [2:0] flg_set = {mev[1], mev[0], ovf_ev};
  wire [2:0] flg_clr = (wr_flg ? wdat[2:0] : 3'b000) | I_IRQ_SVC;
  wire [2:0] flg_d = flg_set | (flg_q & ~flg_clr);

  etc_prescale u_psc (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_async_sel(async_q),
    .i_cs(cs),
    .i_xtal(I_XTAL_OSC),
    .o_tick(tick)
  );

  wire [31:0] rd_mux =
    sel_ca ? {24'h000000, ctrl_a_q} :
    sel_cb ? {24'h000000, ctrl_b_q} :
    sel_cnt ? {24'h000000, cnt_q} :
    sel_ocr[0] ? {24'h000000, ocr_rd[0]} :
    sel_ocr[1] ? {24'h000000, ocr_rd[1]} :
    sel_flg ? {29'h00000000, flg_q} :
    sel_msk ? {29'h00000000, msk_q} :
    sel_asy ? {26'h0000000, async_q, 5'h00} : 32'h00000000;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      rdat_q <= (req & ~ack_q) ? rd_mux : 32'h00000000;
    end
  end
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rdat_q;

  // control, count and flag state; all zero at reset except the direction, which starts up
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_a_q <= '0;
      ctrl_b_q <= '0;
      cnt_q <= REG_RESET;
      dir_up_q <= 1'b1;
      flg_q <= '0;
      msk_q <= '0;
      async_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      if (wr_ca) ctrl_a_q <= {wdat[7:6], wdat[5:4], 2'b00, wdat[1:0]};
      if (wr_cb) ctrl_b_q <= {4'h0, wdat[3], wdat[2:0]};
      if (wr_msk) msk_q <= wdat[2:0];
      if (wr_asy) async_q <= wdat[ASYNC_SEL_BIT];
      cnt_q <= cnt_d;
      if (!pc) dir_up_q <= 1'b1;
      else if (tick && turn_dn && !wr_cnt) dir_up_q <= 1'b0;
      else if (tick && turn_up && !wr_cnt) dir_up_q <= 1'b1;
      flg_q <= flg_d;
      if (wr_cnt) blk_q <= 1'b1;
      else if (tick) blk_q <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) O_IRQ_REQ <= '0;
    else O_IRQ_REQ <= flg_q & msk_q;
  end

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      logic [7:0] ocr_q, buf_q;
      logic oc_q, oc_d, pin_q, oe_q;
      wire up_side = at_bot | (dir_up_q & ~at_top);

      assign match[i] = (cnt_q == ocr_q);
      assign mev[i] = tick & match[i] & ~blk_q & ~wr_cnt;
      assign frc[i] = wr_cb & wdat[7 - i] & ~pwm;
      assign ocr_act[i] = ocr_q;
      assign ocr_rd[i] = pwm ? buf_q : ocr_q;
      assign oc_vec[i] = oc_q;

      always_comb begin
        oc_d = oc_q;
        if (!pwm) begin
          if (mev[i] || frc[i]) begin
            case (com[i])
              COM_TOGGLE: oc_d = ~oc_q;
              COM_CLEAR: oc_d = 1'b0;
              COM_SET: oc_d = 1'b1;
              default: oc_d = oc_q;
            endcase
          end
        end else if (com[i] == COM_TOGGLE) begin
          if (i == 0 && wgm[2] && mev[i]) oc_d = ~oc_q;
        end else if (com[i] != COM_NONE) begin
          // top and bottom settle the extreme compare values
          if (fast && tick && at_top) oc_d = ~com[i][0];
          else if (fast && mev[i]) oc_d = com[i][0];
          else if (mev[i]) oc_d = up_side ? com[i][0] : ~com[i][0];
        end
      end

      always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          ocr_q <= REG_RESET;
          buf_q <= REG_RESET;
          oc_q <= 1'b0;
          pin_q <= 1'b0;
          oe_q <= 1'b0;
        end else begin
          if (wr_ocr[i] && !pwm) ocr_q <= wdat;
          else if (upd && pwm) ocr_q <= buf_q;
          if (wr_ocr[i]) buf_q <= wdat;
          oc_q <= oc_d;
          pin_q <= (com[i] != COM_NONE) ? oc_q : I_PORT_DATA[i];
          oe_q <= I_PORT_DIR[i];
        end
      end
      assign O_CH_PIN[i] = pin_q;
      assign O_CH_PIN_OE[i] = oe_q;
    end
  endgenerate

  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_stopped;
    (cs == CS_STOP) [*2];
  endsequence
  sequence s_bus_req;
    req && !ack_q;
  endsequence

  property p_bus_ack;
    s_bus_req |=> O_WB_ACK ##1 !O_WB_ACK;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus ack not one cycle");

  property p_stop;
    s_stopped ##0 !wr_cnt |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_write_prio;
    wr_cnt |=> cnt_q == $past(wdat);
  endproperty
  a_write_prio: assert property (p_write_prio) else $error("count write lost");

  property p_flag_a;
    tick && match[0] && !blk_q && !wr_cnt |=> flg_q[FLG_CMP_A];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("compare flag a not set");

  property p_block;
    tick && blk_q && !flg_q[FLG_CMP_B] |=> !flg_q[FLG_CMP_B];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_irq;
    1'b1 |=> O_IRQ_REQ == $past(flg_q & msk_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated by mask");

  property p_direct_cmp;
    wr_ocr[0] && !pwm |=> ocr_act[0] == $past(wdat);
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) else $error("direct compare write lost");

  property p_buffered;
    wr_ocr[1] && pwm && !upd |=> $stable(ocr_act[1]);
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffered write reached active");

  property p_transfer;
    upd && pwm && !wr_ocr[0] |=> ocr_act[0] == $past(ocr_rd[0]);
  endproperty
  a_transfer: assert property (p_transfer) else $error("buffer not transferred");

  property p_force;
    frc[0] && com[0] == COM_SET && !flg_q[FLG_CMP_A] && !mev[0] |=> oc_vec[0] && !flg_q[FLG_CMP_A];
  endproperty
  a_force: assert property (p_force) else $error("force compare wrong");

  property p_force_tgl;
    frc[0] && com[0] == COM_TOGGLE && !mev[0] |=> oc_vec[0] != $past(oc_vec[0]);
  endproperty
  a_force_tgl: assert property (p_force_tgl) else $error("forced toggle missed");

  property p_com_none;
    com[1] == COM_NONE |=> $stable(oc_vec[1]);
  endproperty
  a_com_none: assert property (p_com_none) else $error("output moved with mode none");

  property p_ovf;
    wgm == WGM_NORMAL && tick && at_max && !wr_cnt |=> at_bot && flg_q[FLG_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("normal overflow wrong");

  property p_ctc_clear;
    wgm == WGM_CTC && tick && at_top && !wr_cnt |=> at_bot;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear missed");

  property p_count_up;
    wgm == WGM_NORMAL && tick && !wr_cnt |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("normal count step wrong");

  property p_count_down;
    pc && !dir_up_q && tick && !at_bot && !wr_cnt |=> cnt_q == $past(cnt_q) - 8'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("down count step wrong");

  property p_flag_clr;
    wr_flg && wdat[FLG_CMP_B] && !mev[1] |=> !flg_q[FLG_CMP_B];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag write one not cleared");

  property p_pin;
    1'b1 |=> O_CH_PIN[0] == ($past(com[0] != COM_NONE) ? $past(oc_vec[0]) : $past(I_PORT_DATA[0]));
  endproperty
  a_pin: assert property (p_pin) else $error("pin override wrong");

endmodule
`default_nettype wire

/* rtl/etc_pkg.sv */
package etc_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0c;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_ASYNC = 8'h1c;

  localparam int unsigned NUM_CH = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // flag and mask bit positions
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_CMP_A = 1;
  localparam int unsigned FLG_CMP_B = 2;
  // async_clock_select position in async_status_register
  localparam int unsigned ASYNC_SEL_BIT = 5;

  // prescaler tap masks
  localparam logic [9:0] PSC_MASK_8 = 10'h007;
  localparam logic [9:0] PSC_MASK_32 = 10'h01f;
  localparam logic [9:0] PSC_MASK_64 = 10'h03f;
  localparam logic [9:0] PSC_MASK_128 = 10'h07f;
  localparam logic [9:0] PSC_MASK_256 = 10'h0ff;
  localparam logic [9:0] PSC_MASK_1024 = 10'h3ff;

  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_DIV1 = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV32 = 3'b011,
    CS_DIV64 = 3'b100,
    CS_DIV128 = 3'b101,
    CS_DIV256 = 3'b110,
    CS_DIV1024 = 3'b111
  } etc_cs_e;

  typedef enum logic [2:0] {
    WGM_NORMAL = 3'b000,
    WGM_PC_MAX = 3'b001,
    WGM_CTC = 3'b010,
    WGM_FAST_MAX = 3'b011,
    WGM_RSV4 = 3'b100,
    WGM_PC_CMPA = 3'b101,
    WGM_RSV6 = 3'b110,
    WGM_FAST_CMPA = 3'b111
  } etc_wgm_e;

  typedef enum logic [1:0] {
    COM_NONE = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR = 2'b10,
    COM_SET = 2'b11
  } etc_com_e;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsv;
    logic [1:0] wgm_lo;
  } etc_ctrl_a_s;

  typedef struct packed {
    logic foc_a;
    logic foc_b;
    logic [1:0] rsv;
    logic wgm_hi;
    logic [2:0] cs;
  } etc_ctrl_b_s;

endpackage

/* rtl/etc_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
module etc_prescale (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_async_sel,
  input wire etc_pkg::etc_cs_e i_cs,
  // crystal oscillator pin
  input wire logic i_xtal,
  // tick
  output logic o_tick
);
  import etc_pkg::*;

  logic xs1_q, xs2_q, xs3_q;
  logic [9:0] psc_q;
  logic [9:0] tap_mask;
  logic base, tick_d;

  // rising crystal edges become io-clock events after two flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xs3_q <= 1'b0;
    end else begin
      xs1_q <= i_xtal;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
    end
  end

  assign base = i_async_sel ? (xs2_q & ~xs3_q) : 1'b1;

  always_comb begin
    case (i_cs)
      CS_DIV8: tap_mask = PSC_MASK_8;
      CS_DIV32: tap_mask = PSC_MASK_32;
      CS_DIV64: tap_mask = PSC_MASK_64;
      CS_DIV128: tap_mask = PSC_MASK_128;
      CS_DIV256: tap_mask = PSC_MASK_256;
      CS_DIV1024: tap_mask = PSC_MASK_1024;
      default: tap_mask = '0;
    endcase
  end

  // no tick at all while the select is zero
  assign tick_d = (i_cs != CS_STOP) && base && ((psc_q & tap_mask) == tap_mask);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      psc_q <= '0;
      o_tick <= 1'b0;
    end else begin
      if (base) psc_q <= psc_q + 10'h001;
      o_tick <= tick_d;
    end
  end

endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import etc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic xtal = 1'b0;
  logic [2:0] svc = 3'h0;
  logic [1:0] pdat = 2'h0;
  logic [1:0] pdir = 2'h0;
  wire logic [31:0] rdat;
  wire logic ack;
  wire logic [2:0] irq;
  wire logic [1:0] pin;
  wire logic [1:0] oe;
  int errors = 0;
  int checks = 0;
  int k;
  int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0] rnd = 8'h47;
  logic [7:0] rv;
  logic [7:0] v;
  logic [7:0] w;
  etc_wgm_e tm[4] = '{WGM_CTC, WGM_PC_CMPA, WGM_FAST_CMPA, WGM_PC_MAX};

  always #10 clk = ~clk;

  etc_timer dut_u (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_XTAL_OSC(xtal), .O_IRQ_REQ(irq), .I_IRQ_SVC(svc), .I_PORT_DATA(pdat),
    .I_PORT_DIR(pdir), .O_CH_PIN(pin), .O_CH_PIN_OE(oe)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] top_flags(input etc_wgm_e m);
    return (m == WGM_CTC || m == WGM_PC_MAX) ? 8'h02 : 8'h03;
  endfunction

  // highest count a short run may show: compare a or the fixed maximum
  function automatic int top_end(input etc_wgm_e m);
    return (m == WGM_PC_MAX) ? 255 : 5;
  endfunction

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] g);
    checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  task automatic wb(input logic wen, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wen;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= 4'h1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      errors++;
      report_and_stop;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, q);
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic set_mode(input logic [3:0] com, input etc_wgm_e m);
    wr(OFF_CTRL_A, {com, 2'b00, m[1:0]});
    wr(OFF_CTRL_B, {4'h0, m[2], CS_STOP});
  endtask

  task automatic flags(input etc_wgm_e m, input logic [7:0] st, input int n,
                       output logic [7:0] f);
    set_mode(4'h0, m);
    wr(OFF_FLAGS, 8'h07);
    wr(OFF_COUNT, st);
    wr(OFF_CTRL_B, {4'h0, m[2], CS_DIV1});
    cyc_n(n);
    wr(OFF_CTRL_B, {4'h0, m[2], CS_STOP});
    rd(OFF_FLAGS, f);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    report_and_stop;
  end

  initial begin
    cyc_n(12);
    nrst <= 1'b1;
    for (k = 0; k < 9; k++) begin
      rd(8'(k * 4), rv);
      chk("reg_reset", 8'h00, rv);
    end
    wr(8'h20, 8'h5a);
    rd(8'h20, rv);
    chk("unmapped", 8'h00, rv);
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      pdat <= rnd[1:0];
      pdir <= rnd[3:2];
      cyc_n(3);
      chk("pin_b", {7'h0, pdat[1]}, {7'h0, pin[1]});
      chk("pin_oe", {6'h0, pdir}, {6'h0, oe});
    end
    rnd = lfsr(rnd);
    wr(OFF_COUNT, rnd);
    cyc_n(20);
    rd(OFF_COUNT, rv);
    chk("count_stopped", rnd, rv);
    rnd = lfsr(rnd);
    v = {2'b01, rnd[5:0]};
    wr(OFF_CMP_A, v);
    wr(OFF_CMP_B, v + 8'h60);
    flags(WGM_NORMAL, v - 8'h04, 10, rv);
    chk("flags_cmp_a", 8'h02, rv);
    wr(OFF_MASK, 8'h02);
    cyc_n(3);
    chk("irq_set", 8'h02, {5'h0, irq});
    wr(OFF_FLAGS, 8'h02);
    cyc_n(3);
    chk("irq_clr", 8'h00, {5'h0, irq});
    rd(OFF_FLAGS, rv);
    chk("flag_w1c", 8'h00, rv);
    flags(WGM_NORMAL, v - 8'h04, 10, rv);
    svc <= 3'b010;
    @(posedge clk);
    svc <= 3'b000;
    rd(OFF_FLAGS, rv);
    chk("flag_svc", 8'h00, rv);
    w = v + 8'h20;
    wr(OFF_CMP_B, w);
    flags(WGM_NORMAL, w, 10, rv);
    chk("match_blocked", 8'h00, rv);
    flags(WGM_NORMAL, 8'hfa, 12, rv);
    chk("overflow", 8'h01, rv);
    wr(OFF_CMP_A, 8'h05);
    for (k = 0; k < 4; k++) begin
      set_mode(4'h0, tm[k]);
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRL_B, {4'h0, tm[k][2], CS_DIV1});
      repeat (6) begin
        rd(OFF_COUNT, rv);
        chk_rng("top_count", 0, top_end(tm[k]), rv);
      end
      wr(OFF_CTRL_B, {4'h0, tm[k][2], CS_STOP});
      rd(OFF_FLAGS, rv);
      chk("top_flags", top_flags(tm[k]), rv);
    end
    set_mode(4'h0, WGM_NORMAL);
    wr(OFF_CMP_B, 8'h40);
    set_mode(4'h0, WGM_FAST_MAX);
    wr(OFF_CMP_B, 8'h80);
    rd(OFF_CMP_B, rv);
    chk("cmp_buf_read", 8'h80, rv);
    flags(WGM_FAST_MAX, 8'h3c, 10, rv);
    chk("cmp_old_active", 8'h04, rv & 8'h04);
    flags(WGM_FAST_MAX, 8'hfa, 12, rv);
    flags(WGM_FAST_MAX, 8'h7c, 10, rv);
    chk("cmp_new_active", 8'h04, rv & 8'h04);
    set_mode(4'h4, WGM_NORMAL);
    cyc_n(3);
    chk("pin_a_init", 8'h00, {7'h0, pin[0]});
    wr(OFF_FLAGS, 8'h07);
    wr(OFF_CTRL_B, 8'h80);
    cyc_n(3);
    chk("pin_a_forced", 8'h01, {7'h0, pin[0]});
    pdir <= 2'b11;
    cyc_n(3);
    chk("pin_a_oe_on", 8'h03, {6'h0, oe});
    rd(OFF_FLAGS, rv);
    chk("force_no_flag", 8'h00, rv);
    set_mode(4'h4, WGM_FAST_MAX);
    cyc_n(3);
    chk("pin_a_kept", 8'h01, {7'h0, pin[0]});
    wr(OFF_CTRL_B, 8'h80);
    cyc_n(3);
    chk("pin_a_pwm_force", 8'h01, {7'h0, pin[0]});
    wr(OFF_CTRL_A, 8'h00);
    cyc_n(3);
    chk("pin_a_port", {7'h0, pdat[0]}, {7'h0, pin[0]});
    set_mode(4'h8, WGM_NORMAL);
    wr(OFF_CTRL_B, 8'h80);
    cyc_n(3);
    chk("pin_a_force_clr", 8'h00, {7'h0, pin[0]});
    set_mode(4'hc, WGM_NORMAL);
    wr(OFF_CTRL_B, 8'h80);
    cyc_n(3);
    chk("pin_a_force_set", 8'h01, {7'h0, pin[0]});
    set_mode(4'h0, WGM_NORMAL);
    wr(OFF_COUNT, 8'h00);
    wr(OFF_ASYNC, 8'h20);
    wr(OFF_CTRL_B, {5'h0, CS_DIV1});
    cyc_n(20);
    rd(OFF_COUNT, rv);
    chk("async_idle", 8'h00, rv);
    repeat (6) begin
      xtal <= 1'b1;
      cyc_n(4);
      xtal <= 1'b0;
      cyc_n(4);
    end
    cyc_n(6);
    rd(OFF_COUNT, rv);
    chk("async_count", 8'h06, rv);
    wr(OFF_CTRL_B, 8'h00);
    wr(OFF_ASYNC, 8'h00);
    for (k = 1; k < 8; k++) begin
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRL_B, 8'(k));
      cyc_n(8 * dv[k]);
      wr(OFF_CTRL_B, 8'h00);
      rd(OFF_COUNT, rv);
      chk_rng("psc_count", 7, 13, rv);
    end
    wr(OFF_COUNT, 8'h99);
    nrst <= 1'b0;
    cyc_n(3);
    nrst <= 1'b1;
    rd(OFF_COUNT, rv);
    chk("count_rst", 8'h00, rv);
    rd(OFF_CMP_B, rv);
    chk("cmp_rst", 8'h00, rv);
    report_and_stop;
  end
endmodule
`default_nettype wire
